// ==== verif/ir_led_stage.sv ====
// behavioural model of the infrared emitter stage on the carrier pin
// assumes the pin is sampled on aclk and a resistor pulls it high when released
`timescale 1ns/1ns
module ir_led_stage (
   input wire logic aclk,
   input wire logic drive_level,
   input wire logic drive_en,
   output logic pin_level,
   output logic [9:0] low_len,
   output logic [9:0] high_len
);
   // ==========================================
   // pin level and pulse width measurement
   logic [9:0] run_len = 10'h000;
   logic last_level = 1'b1;
   // released pin goes to the pull-up level
   assign pin_level = drive_en ? drive_level : 1'b1;
   initial begin
      low_len = 10'h000;
      high_len = 10'h000;
   end
   always @(posedge aclk) begin
      if (pin_level != last_level) begin
         if (last_level) begin
            high_len <= run_len;
         end else begin
            low_len <= run_len;
         end
         run_len <= 10'h001;
      end else begin
         run_len <= run_len + 10'h001;
      end
      last_level <= pin_level;
   end
endmodule

// ==== verif/test_ir_carrier_generator.sv ====
// self-checking bench for the carrier generator over axi4-lite
// assumes byte address = register index times four, emitter model on the pin
`timescale 1ns/1ns
module test_ir_carrier_generator;
   // ==========================================
   // signals
   localparam logic [11:0] A_RLD = 12'h334;
   localparam logic [11:0] A_MODE = 12'h368;
   localparam logic [11:0] A_CNT = 12'h36C;
   localparam logic [11:0] A_DUTY = 12'h3A0;
   localparam logic [11:0] A_BAD = 12'hFFC;
   logic aclk = 1'b0;
   logic aresetn = 1'b0;
   logic [11:0] awaddr = 12'h000;
   logic [11:0] araddr = 12'h000;
   logic [31:0] wdata = 32'h0;
   logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
   logic power_down = 1'b0, port_out = 1'b0, port_oe = 1'b0;
   logic awready, wready, bvalid, arready, rvalid, port_in, pin_o, pin_oe, pin_lvl;
   logic [1:0] bresp, rresp;
   logic [31:0] rdata, got_d, got_r, tmp;
   logic [9:0] low_len, high_len;
   logic [7:0] rl [2] = '{8'hFC, 8'h97};
   logic [7:0] dt [2] = '{8'hFE, 8'hBA};
   int n_errors = 0;
   int total_checks = 0;

   always #10 aclk = ~aclk;

   ir_carrier_generator #(.ADDR_W(12)) i_dut (
      .aclk(aclk), .aresetn(aresetn),
      .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
      .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
      .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
      .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
      .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
      .power_down(power_down), .port_out(port_out), .port_oe(port_oe), .port_in(port_in),
      .carrier_pin_i(pin_lvl), .carrier_pin_o(pin_o), .carrier_pin_oe(pin_oe)
   );

   ir_led_stage i_led (
      .aclk(aclk), .drive_level(pin_o), .drive_en(pin_oe),
      .pin_level(pin_lvl), .low_len(low_len), .high_len(high_len)
   );

   // ==========================================
   // bus tasks and compares
   task automatic wr(input logic [11:0] a, input logic [31:0] d);
      @(posedge aclk);
      awaddr <= a;
      wdata <= d;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (awvalid && awready) awvalid <= 1'b0;
         if (wvalid && wready) wvalid <= 1'b0;
         if (bvalid && bready) begin
            got_r = {30'h0, bresp};
            bready <= 1'b0;
            return;
         end
      end
   endtask

   task automatic rd(input logic [11:0] a);
      @(posedge aclk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge aclk);
         if (arvalid && arready) arvalid <= 1'b0;
         if (rvalid && rready) begin
            got_d = rdata;
            got_r = {30'h0, rresp};
            rready <= 1'b0;
            return;
         end
      end
   endtask

   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      total_checks++;
      if (got !== exp) begin
         n_errors++;
         $display("wrong value at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   task automatic chk_pin(input logic [1:0] got, input logic [1:0] exp);
      chk({30'h0, got}, {30'h0, exp});
   endtask

   task automatic conclude();
      $display("checks %0d errors %0d", total_checks, n_errors);
      if (n_errors == 0 && total_checks > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask

   // ==========================================
   // tests
   initial begin
      repeat (5000) @(posedge aclk);
      n_errors++;
      conclude();
   end

   initial begin
      repeat (16) @(posedge aclk);
      aresetn <= 1'b1;
      rd(A_MODE);
      chk(got_d, 32'h0);
      chk(got_r, 32'h0);
      rd(A_CNT);
      chk(got_d, 32'h0);
      rd(A_BAD);
      chk(got_r, 32'h2);
      wr(A_BAD, 32'h3);
      chk(got_r, 32'h2);
      port_oe <= 1'b1;
      wr(A_MODE, 32'h1);
      chk(got_r, 32'h0);
      repeat (4) @(posedge aclk);
      chk_pin({pin_oe, pin_o}, 2'b10);
      rd(A_MODE);
      chk(got_d, 32'h1);
      wr(A_MODE, 32'h0);
      port_oe <= 1'b0;
      repeat (5) @(posedge aclk);
      chk_pin({pin_oe, port_in}, 2'b01);
      wr(A_MODE, 32'h2);
      repeat (4) @(posedge aclk);
      chk_pin({pin_oe, pin_o}, 2'b11);
      wr(A_CNT, 32'h55);
      repeat (10) @(posedge aclk);
      rd(A_CNT);
      chk(got_d, 32'h55);
      for (int i = 0; i < 2; i++) begin
         wr(A_MODE, 32'h2);
         wr(A_RLD, {24'h0, rl[i]});
         wr(A_DUTY, {24'h0, dt[i]});
         wr(A_CNT, {24'h0, rl[i]});
         wr(A_MODE, 32'h3);
         repeat (300) @(posedge aclk);
         chk({22'h0, low_len}, {24'h0, dt[i]} - {24'h0, rl[i]});
         chk({22'h0, high_len}, 32'h100 - {24'h0, dt[i]});
      end
      wr(A_RLD, 32'hA0);
      repeat (400) @(posedge aclk);
      chk({22'h0, low_len}, 32'h1A);
      chk({22'h0, high_len}, 32'h46);
      power_down <= 1'b1;
      repeat (6) @(posedge aclk);
      chk_pin({pin_oe, pin_o}, 2'b11);
      rd(A_CNT);
      tmp = got_d;
      repeat (7) @(posedge aclk);
      rd(A_CNT);
      chk(got_d, tmp);
      power_down <= 1'b0;
      conclude();
   end
endmodule

// ==== verilog/carrier_map.svh ====
// register indices, bit positions, reset values and bus codes of the carrier generator
// assumes byte address = register index times four on a 32-bit bus
`ifndef CARRIER_MAP_SVH
`define CARRIER_MAP_SVH
// ==========================================================
// register indices
`define IDX_CYCLE_RELOAD 8'hCD
`define IDX_CARRIER_MODE 8'hDA
`define IDX_CARRIER_COUNTER 8'hDB
`define IDX_DUTY_COMPARE 8'hE8
// ==========================================================
// fields and values
`define ADDR_LSB 2
`define IDX_W 8
`define BIT_CARRIER_EN 0
`define BIT_PIN_FUNC 1
`define RST_BYTE 8'h00
`define CNT_TOP 8'hFF
`define CNT_STEP 8'h01
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2
`endif

// ==== verilog/carrier_pkg.sv ====
// types shared by the carrier generator
// assumes carrier_map.svh supplies the numeric constants
package carrier_pkg;
   typedef enum logic [0:0] {
      PHASE_LOW = 1'b0,
      PHASE_HIGH = 1'b1
   } phase_t;
   typedef enum logic [2:0] {
      SEL_NONE = 3'b000,
      SEL_RELOAD = 3'b001,
      SEL_MODE = 3'b010,
      SEL_COUNT = 3'b011,
      SEL_DUTY = 3'b100
   } reg_sel_t;
endpackage

// ==== verilog/ir_carrier_generator.sv ====
// ir carrier generator with an axi4-lite register slave
// assumes aclk is the high-speed oscillator; power_down and the pin input are asynchronous
//
// Our own choice: register access over AXI4-Lite.
`timescale 1ns/1ns
`include "carrier_map.svh"

module ir_carrier_generator #(
   parameter int ADDR_W = 12
) (
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic [ADDR_W-1:0] s_axi_awaddr,
   input wire logic s_axi_awvalid,
   output logic s_axi_awready,
   input wire logic [31:0] s_axi_wdata,
   input wire logic [3:0] s_axi_wstrb,
   input wire logic s_axi_wvalid,
   output logic s_axi_wready,
   output logic [1:0] s_axi_bresp,
   output logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic [ADDR_W-1:0] s_axi_araddr,
   input wire logic s_axi_arvalid,
   output logic s_axi_arready,
   output logic [31:0] s_axi_rdata,
   output logic [1:0] s_axi_rresp,
   output logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic power_down,
   input wire logic port_out,
   input wire logic port_oe,
   output logic port_in,
   input wire logic carrier_pin_i,
   output logic carrier_pin_o,
   output logic carrier_pin_oe
);

   // ==========================================================
   // elaboration check
   if (ADDR_W < `ADDR_LSB + `IDX_W + 1 || ADDR_W > 32) begin : g_bad_addr_w
      $error("ADDR_W must lie between 11 and 32");
   end

   // ==========================================================
   // address decode
   function automatic carrier_pkg::reg_sel_t decode(input logic [ADDR_W-1:0] addr);
      logic [`IDX_W-1:0] idx;
      carrier_pkg::reg_sel_t sel;
      idx = addr[`ADDR_LSB +: `IDX_W];
      sel = carrier_pkg::SEL_NONE;
      if (addr[ADDR_W-1:`ADDR_LSB+`IDX_W] == '0 && addr[`ADDR_LSB-1:0] == '0) begin
         case (idx)
            `IDX_CYCLE_RELOAD: sel = carrier_pkg::SEL_RELOAD;
            `IDX_CARRIER_MODE: sel = carrier_pkg::SEL_MODE;
            `IDX_CARRIER_COUNTER: sel = carrier_pkg::SEL_COUNT;
            `IDX_DUTY_COMPARE: sel = carrier_pkg::SEL_DUTY;
            default: sel = carrier_pkg::SEL_NONE;
         endcase
      end
      return sel;
   endfunction

   // ==========================================================
   // state
   logic aw_held_q, aw_held_d, w_held_q, w_held_d, bvalid_q, bvalid_d;
   logic [ADDR_W-1:0] awaddr_q, awaddr_d;
   logic [7:0] wdata_q, wdata_d;
   logic wstrb0_q, wstrb0_d;
   logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
   logic rvalid_q, rvalid_d;
   logic [31:0] rdata_q, rdata_d;
   logic pin_func_q, pin_func_d, en_q, en_d;
   logic [7:0] cnt_q, cnt_d, buf_q, buf_d, active_q, active_d, duty_q, duty_d;
   logic [7:0] cnt_inc;
   carrier_pkg::phase_t phase_q, phase_d;
   logic pd_meta_q, pd_q, pin_meta_q, pin_sync_q;
   logic pin_o_q, pin_o_d, pin_oe_q, pin_oe_d;
   logic do_write, wr_en, run, wr_cnt, wr_reload, wr_mode, wr_duty;
   carrier_pkg::reg_sel_t wsel, rsel;

   assign s_axi_awready = !aw_held_q;
   assign s_axi_wready = !w_held_q;
   assign s_axi_arready = !rvalid_q;
   assign s_axi_bvalid = bvalid_q;
   assign s_axi_bresp = bresp_q;
   assign s_axi_rvalid = rvalid_q;
   assign s_axi_rdata = rdata_q;
   assign s_axi_rresp = rresp_q;
   assign carrier_pin_o = pin_o_q;
   assign carrier_pin_oe = pin_oe_q;
   assign port_in = pin_sync_q;

   // ==========================================================
   // write channel
   assign do_write = aw_held_q && w_held_q && !bvalid_q;
   assign wsel = decode(awaddr_q);
   assign wr_en = do_write && wstrb0_q;
   assign wr_reload = wr_en && wsel == carrier_pkg::SEL_RELOAD;
   assign wr_mode = wr_en && wsel == carrier_pkg::SEL_MODE;
   assign wr_cnt = wr_en && wsel == carrier_pkg::SEL_COUNT;
   assign wr_duty = wr_en && wsel == carrier_pkg::SEL_DUTY;

   always_comb begin
      aw_held_d = aw_held_q;
      w_held_d = w_held_q;
      awaddr_d = awaddr_q;
      wdata_d = wdata_q;
      wstrb0_d = wstrb0_q;
      bvalid_d = bvalid_q;
      bresp_d = bresp_q;
      if (s_axi_awvalid && !aw_held_q) begin
         aw_held_d = 1'b1;
         awaddr_d = s_axi_awaddr;
      end
      if (s_axi_wvalid && !w_held_q) begin
         w_held_d = 1'b1;
         wdata_d = s_axi_wdata[7:0];
         wstrb0_d = s_axi_wstrb[0];
      end
      if (do_write) begin
         aw_held_d = 1'b0;
         w_held_d = 1'b0;
         bvalid_d = 1'b1;
         bresp_d = (wsel == carrier_pkg::SEL_NONE) ? `RESP_SLVERR : `RESP_OKAY;
      end else if (bvalid_q && s_axi_bready) begin
         bvalid_d = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         aw_held_q <= 1'b0;
         w_held_q <= 1'b0;
         awaddr_q <= '0;
         wdata_q <= `RST_BYTE;
         wstrb0_q <= 1'b0;
         bvalid_q <= 1'b0;
         bresp_q <= `RESP_OKAY;
      end else begin
         aw_held_q <= aw_held_d;
         w_held_q <= w_held_d;
         awaddr_q <= awaddr_d;
         wdata_q <= wdata_d;
         wstrb0_q <= wstrb0_d;
         bvalid_q <= bvalid_d;
         bresp_q <= bresp_d;
      end
   end

   // ==========================================================
   // read channel
   assign rsel = decode(s_axi_araddr);

   always_comb begin
      rvalid_d = rvalid_q;
      rdata_d = rdata_q;
      rresp_d = rresp_q;
      if (s_axi_arvalid && !rvalid_q) begin
         rvalid_d = 1'b1;
         rresp_d = `RESP_OKAY;
         rdata_d = '0;
         case (rsel)
            carrier_pkg::SEL_MODE: begin
               rdata_d[`BIT_PIN_FUNC] = pin_func_q;
               rdata_d[`BIT_CARRIER_EN] = en_q;
            end
            carrier_pkg::SEL_COUNT: rdata_d[7:0] = cnt_q;
            carrier_pkg::SEL_RELOAD, carrier_pkg::SEL_DUTY: rdata_d = '0;
            default: rresp_d = `RESP_SLVERR;
         endcase
      end else if (rvalid_q && s_axi_rready) begin
         rvalid_d = 1'b0;
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         rvalid_q <= 1'b0;
         rdata_q <= '0;
         rresp_q <= `RESP_OKAY;
      end else begin
         rvalid_q <= rvalid_d;
         rdata_q <= rdata_d;
         rresp_q <= rresp_d;
      end
   end

   // ==========================================================
   // synchronisers for power-down and pin level
   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pd_meta_q <= 1'b0;
         pd_q <= 1'b0;
         pin_meta_q <= 1'b1;
         pin_sync_q <= 1'b1;
      end else begin
         pd_meta_q <= power_down;
         pd_q <= pd_meta_q;
         pin_meta_q <= carrier_pin_i;
         pin_sync_q <= pin_meta_q;
      end
   end

   // ==========================================================
   // carrier counter and phase, no interrupt or flag is produced
   assign run = en_q && !pd_q;
   assign cnt_inc = cnt_q + `CNT_STEP;

   always_comb begin
      pin_func_d = pin_func_q;
      en_d = en_q;
      cnt_d = cnt_q;
      buf_d = buf_q;
      active_d = active_q;
      duty_d = duty_q;
      phase_d = phase_q;
      if (wr_mode) begin
         pin_func_d = wdata_q[`BIT_PIN_FUNC];
         en_d = wdata_q[`BIT_CARRIER_EN];
      end
      if (wr_duty) begin
         duty_d = wdata_q;
      end
      if (wr_reload) begin
         buf_d = wdata_q;
      end
      if (wr_cnt) begin
         cnt_d = wdata_q;
      end else if (wr_mode && wdata_q[`BIT_CARRIER_EN] && !en_q) begin
         cnt_d = buf_q;
         active_d = buf_q;
         phase_d = carrier_pkg::PHASE_LOW;
      end else if (run) begin
         if (cnt_q == `CNT_TOP) begin
            cnt_d = active_q;
            active_d = buf_q;
            phase_d = (active_q == duty_q) ? carrier_pkg::PHASE_HIGH
                                           : carrier_pkg::PHASE_LOW;
         end else begin
            cnt_d = cnt_inc;
            if (cnt_inc == duty_q) begin
               phase_d = carrier_pkg::PHASE_HIGH;
            end
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_func_q <= 1'b0;
         en_q <= 1'b0;
         cnt_q <= `RST_BYTE;
         buf_q <= `RST_BYTE;
         active_q <= `RST_BYTE;
         duty_q <= `RST_BYTE;
         phase_q <= carrier_pkg::PHASE_LOW;
      end else begin
         pin_func_q <= pin_func_d;
         en_q <= en_d;
         cnt_q <= cnt_d;
         buf_q <= buf_d;
         active_q <= active_d;
         duty_q <= duty_d;
         phase_q <= phase_d;
      end
   end

   // ==========================================================
   // pin multiplexer
   always_comb begin
      pin_o_d = port_out;
      pin_oe_d = port_oe;
      if (pin_func_q) begin
         pin_oe_d = 1'b1;
         if (!en_q || pd_q) begin
            pin_o_d = 1'b1;
         end else begin
            pin_o_d = (phase_q == carrier_pkg::PHASE_HIGH);
         end
      end
   end

   always_ff @(posedge aclk) begin
      if (!aresetn) begin
         pin_o_q <= 1'b0;
         pin_oe_q <= 1'b0;
      end else begin
         pin_o_q <= pin_o_d;
         pin_oe_q <= pin_oe_d;
      end
   end

   // ==========================================================
   // assertions
   default clocking cb @(posedge aclk); endclocking
   default disable iff (!aresetn);

   sequence seq_wrap;
      run && cnt_q == `CNT_TOP && !wr_cnt && !wr_mode;
   endsequence

   sequence seq_step;
      run && cnt_q != `CNT_TOP && !wr_cnt && !wr_mode;
   endsequence

   AST_WRAP_RELOAD: assert property (seq_wrap |=> cnt_q == $past(active_q) &&
      phase_q == ($past(active_q) == $past(duty_q) ? carrier_pkg::PHASE_HIGH
      : carrier_pkg::PHASE_LOW))
      else $error("overflow did not reload counter");
   AST_COUNT_UP: assert property (seq_step |=> cnt_q == $past(cnt_inc))
      else $error("counter did not step by one");
   AST_HOLD: assert property (!run && !wr_cnt && !wr_mode |=> $stable(cnt_q))
      else $error("counter moved while stopped");
   AST_DUTY_HIGH: assert property (seq_step ##0 cnt_inc == duty_q |=>
      phase_q == carrier_pkg::PHASE_HIGH)
      else $error("compare did not raise output");
   AST_BUFFERED: assert property (wr_reload && !(run && cnt_q == `CNT_TOP) && !wr_mode
      |=> active_q == $past(active_q) && buf_q == $past(wdata_q))
      else $error("reload bypassed holding buffer");
   AST_ENABLE_LOW: assert property ($rose(en_q) && !$past(wr_cnt) |-> phase_q ==
      carrier_pkg::PHASE_LOW && cnt_q == $past(buf_q))
      else $error("enable did not start low from reload");
   AST_PIN_HIGH: assert property (pin_func_q && (!en_q || pd_q) |=> carrier_pin_o &&
      carrier_pin_oe)
      else $error("pin not high while disabled");
   AST_PORT_PIN: assert property (!pin_func_q |=> carrier_pin_o == $past(port_out) &&
      carrier_pin_oe == $past(port_oe))
      else $error("port pin not passed through");
   AST_WAVE: assert property (pin_func_q && run |=> carrier_pin_oe &&
      carrier_pin_o == $past(phase_q == carrier_pkg::PHASE_HIGH))
      else $error("waveform not on pin");
   AST_CNT_WRITE: assert property (wr_cnt |=> cnt_q == $past(wdata_q) &&
      $stable(phase_q))
      else $error("counter write mishandled");

endmodule
